//--- cpuamd_cfg.svh
// Constants for the addressing-mode decoder: prebytes, opcode rows, limits
`ifndef CPUAMD_CFG_SVH
`define CPUAMD_CFG_SVH

// Prebyte codes
`define CPUAMD_PRE_Y 8'h90
`define CPUAMD_PRE_IND 8'h92
`define CPUAMD_PRE_IND_Y 8'h91

// Low-power inherent opcodes
`define CPUAMD_OPC_WAIT 8'h8f
`define CPUAMD_OPC_HALT 8'h8e

// Opcode high-nibble rows
`define CPUAMD_ROW_BTJ 4'h0
`define CPUAMD_ROW_BIT 4'h1
`define CPUAMD_ROW_JREL 4'h2
`define CPUAMD_ROW_RMW_DIR 4'h3
`define CPUAMD_ROW_RMW_IDXS 4'h6
`define CPUAMD_ROW_RMW_IDX0 4'h7
`define CPUAMD_ROW_IMM 4'ha
`define CPUAMD_ROW_DIR 4'hb
`define CPUAMD_ROW_DIRL 4'hc
`define CPUAMD_ROW_IDXL 4'hd
`define CPUAMD_ROW_IDXS 4'he
`define CPUAMD_ROW_IDX0 4'hf

// Address limits and counts
`define CPUAMD_PAGE0 8'h00
`define CPUAMD_SHORT_IDX_MAX 16'h01fe
`define CPUAMD_ONE_BYTE 3'h1
`define CPUAMD_LEN_OPC 3'h1
`define CPUAMD_LEN_PRE 3'h1

`endif

//--- cpuamd_pkg.sv
// Types for the addressing-mode decoder
package cpuamd_pkg;

  typedef enum logic [4:0] {
    AM_INHERENT = 5'h00,
    AM_IMMEDIATE = 5'h01,
    AM_DIR_SHORT = 5'h02,
    AM_DIR_LONG = 5'h03,
    AM_IDX_NONE = 5'h04,
    AM_IDX_SHORT = 5'h05,
    AM_IDX_LONG = 5'h06,
    AM_IND_SHORT = 5'h07,
    AM_IND_LONG = 5'h08,
    AM_IND_IDX_SHORT = 5'h09,
    AM_IND_IDX_LONG = 5'h0a,
    AM_REL_DIR = 5'h0b,
    AM_REL_IND = 5'h0c,
    AM_BIT_DIR = 5'h0d,
    AM_BIT_IND = 5'h0e,
    AM_BIT_DIR_REL = 5'h0f,
    AM_BIT_IND_REL = 5'h10
  } cpuamd_mode_e;

  typedef enum logic [1:0] {
    PRE_NONE = 2'h0,
    PRE_Y = 2'h1,
    PRE_IND = 2'h2,
    PRE_IND_Y = 2'h3
  } cpuamd_pre_e;

  typedef enum logic [5:0] {
    S_OPC = 6'b000001,
    S_OPR1 = 6'b000010,
    S_OPR2 = 6'b000100,
    S_PTR1 = 6'b001000,
    S_PTR2 = 6'b010000,
    S_DONE = 6'b100000
  } cpuamd_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic [15:0] addr;
  } cpuamd_prog_s;

  typedef struct packed {
    cpuamd_mode_e mode;
    cpuamd_pre_e pre;
    logic use_y;
    logic rmw;
    logic [2:0] length;
    logic [7:0] operand;
    logic [15:0] ea;
    logic [15:0] pc_next;
    logic [15:0] target;
  } cpuamd_result_s;

endpackage

//--- cpuamd_addr_add.sv
// Address adder: 16-bit base plus 8-bit addend, unsigned or sign-extended
`timescale 1ns/100ps
module cpuamd_addr_add (
  input wire logic [15:0] base,
  input wire logic [7:0] addend,
  input wire logic sign_ext,
  output logic [15:0] sum
);
  logic [15:0] wide;

  always_comb begin
    wide = {(sign_ext ? {8{addend[7]}} : 8'h00), addend};
    // Carry out of bit 15 wraps, as the address space does
    sum = base + wide;
  end
endmodule

//--- cpuamd_decoder.sv
// Addressing-mode decoder and effective-address former for the 8-bit core
`timescale 1ns/100ps
`include "cpuamd_cfg.svh"
module cpuamd_decoder
  import cpuamd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic prog_valid,
  input wire cpuamd_prog_s prog,
  output logic prog_ready,
  output logic mem_rd_req,
  output logic [15:0] mem_rd_addr,
  input wire logic mem_rd_valid,
  input wire logic [7:0] mem_rd_data,
  input wire logic [7:0] idx_x,
  input wire logic [7:0] idx_y,
  output logic dec_valid,
  output cpuamd_result_s dec,
  output logic wait_req,
  output logic halt_req
);

  function automatic logic is_prebyte(input logic [7:0] b);
    is_prebyte = (b == `CPUAMD_PRE_Y) || (b == `CPUAMD_PRE_IND) || (b == `CPUAMD_PRE_IND_Y);
  endfunction

  function automatic cpuamd_pre_e pre_of(input logic [7:0] b);
    if (b == `CPUAMD_PRE_Y) begin
      pre_of = PRE_Y;
    end else if (b == `CPUAMD_PRE_IND) begin
      pre_of = PRE_IND;
    end else if (b == `CPUAMD_PRE_IND_Y) begin
      pre_of = PRE_IND_Y;
    end else begin
      pre_of = PRE_NONE;
    end
  endfunction

  // Every read-modify-write row maps to a short or pointer-byte form only
  function automatic cpuamd_mode_e mode_of(input cpuamd_pre_e p, input logic [7:0] op);
    logic ind;
    ind = (p == PRE_IND) || (p == PRE_IND_Y);
    case (op[7:4])
      `CPUAMD_ROW_BTJ: mode_of = ind ? AM_BIT_IND_REL : AM_BIT_DIR_REL;
      `CPUAMD_ROW_BIT: mode_of = ind ? AM_BIT_IND : AM_BIT_DIR;
      `CPUAMD_ROW_JREL: mode_of = ind ? AM_REL_IND : AM_REL_DIR;
      `CPUAMD_ROW_RMW_DIR: mode_of = ind ? AM_IND_SHORT : AM_DIR_SHORT;
      `CPUAMD_ROW_RMW_IDXS: mode_of = ind ? AM_IND_IDX_SHORT : AM_IDX_SHORT;
      `CPUAMD_ROW_RMW_IDX0: mode_of = AM_IDX_NONE;
      `CPUAMD_ROW_IMM: mode_of = AM_IMMEDIATE;
      `CPUAMD_ROW_DIR: mode_of = ind ? AM_IND_SHORT : AM_DIR_SHORT;
      `CPUAMD_ROW_DIRL: mode_of = ind ? AM_IND_LONG : AM_DIR_LONG;
      `CPUAMD_ROW_IDXL: mode_of = ind ? AM_IND_IDX_LONG : AM_IDX_LONG;
      `CPUAMD_ROW_IDXS: mode_of = ind ? AM_IND_IDX_SHORT : AM_IDX_SHORT;
      `CPUAMD_ROW_IDX0: mode_of = AM_IDX_NONE;
      default: mode_of = AM_INHERENT;
    endcase
  endfunction

  function automatic logic is_rmw_row(input logic [7:0] op);
    is_rmw_row = (op[7:4] == `CPUAMD_ROW_BTJ) || (op[7:4] == `CPUAMD_ROW_BIT)
      || (op[7:4] == `CPUAMD_ROW_RMW_DIR) || (op[7:4] == `CPUAMD_ROW_RMW_IDXS)
      || (op[7:4] == `CPUAMD_ROW_RMW_IDX0);
  endfunction

  // Bytes that follow the opcode in the program stream
  function automatic logic [1:0] opnd_bytes(input cpuamd_mode_e m);
    case (m)
      AM_INHERENT, AM_IDX_NONE: opnd_bytes = 2'h0;
      AM_DIR_LONG, AM_IDX_LONG: opnd_bytes = 2'h2;
      AM_BIT_DIR_REL, AM_BIT_IND_REL: opnd_bytes = 2'h2;
      default: opnd_bytes = 2'h1;
    endcase
  endfunction

  // Pointer bytes read from page zero
  function automatic logic [1:0] ptr_reads(input cpuamd_mode_e m);
    case (m)
      AM_IND_LONG, AM_IND_IDX_LONG: ptr_reads = 2'h2;
      AM_IND_SHORT, AM_IND_IDX_SHORT, AM_REL_IND: ptr_reads = 2'h1;
      AM_BIT_IND, AM_BIT_IND_REL: ptr_reads = 2'h1;
      default: ptr_reads = 2'h0;
    endcase
  endfunction

  cpuamd_state_e state, next_state;
  cpuamd_pre_e pre, next_pre;
  cpuamd_mode_e mode, next_mode;
  logic [7:0] opc, next_opc, b1, next_b1, b2, next_b2, p0, next_p0, p1, next_p1;
  logic [15:0] last_addr, next_last_addr;
  logic [2:0] len, next_len;
  logic take;

  assign take = prog_valid && prog_ready;

  always_comb begin
    next_state = state;
    next_pre = pre;
    next_mode = mode;
    next_opc = opc;
    next_b1 = b1;
    next_b2 = b2;
    next_p0 = p0;
    next_p1 = p1;
    next_last_addr = last_addr;
    next_len = len;
    case (state)
      S_OPC: begin
        if (take) begin
          next_last_addr = prog.addr;
          next_len = 3'(len + `CPUAMD_ONE_BYTE);
          // A second prebyte is taken as an opcode, not stacked
          if (pre == PRE_NONE && is_prebyte(prog.data)) begin
            next_pre = pre_of(prog.data);
          end else begin
            next_opc = prog.data;
            next_mode = mode_of(pre, prog.data);
            if (opnd_bytes(next_mode) != 2'h0) begin
              next_state = S_OPR1;
            end else begin
              next_state = S_DONE;
            end
          end
        end
      end
      S_OPR1: begin
        if (take) begin
          next_b1 = prog.data;
          next_last_addr = prog.addr;
          next_len = 3'(len + `CPUAMD_ONE_BYTE);
          if (opnd_bytes(mode) == 2'h2) begin
            next_state = S_OPR2;
          end else if (ptr_reads(mode) != 2'h0) begin
            next_state = S_PTR1;
          end else begin
            next_state = S_DONE;
          end
        end
      end
      S_OPR2: begin
        if (take) begin
          next_b2 = prog.data;
          next_last_addr = prog.addr;
          next_len = 3'(len + `CPUAMD_ONE_BYTE);
          next_state = (ptr_reads(mode) != 2'h0) ? S_PTR1 : S_DONE;
        end
      end
      S_PTR1: begin
        if (mem_rd_valid) begin
          next_p0 = mem_rd_data;
          next_state = (ptr_reads(mode) == 2'h2) ? S_PTR2 : S_DONE;
        end
      end
      S_PTR2: begin
        if (mem_rd_valid) begin
          next_p1 = mem_rd_data;
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        next_state = S_OPC;
        next_pre = PRE_NONE;
        next_len = 3'h0;
      end
      default: begin
        next_state = S_OPC;
        next_pre = PRE_NONE;
        next_len = 3'h0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_OPC;
      pre <= PRE_NONE;
      mode <= AM_INHERENT;
      opc <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      p0 <= 8'h00;
      p1 <= 8'h00;
      last_addr <= 16'h0000;
      len <= 3'h0;
    end else begin
      state <= next_state;
      pre <= next_pre;
      mode <= next_mode;
      opc <= next_opc;
      b1 <= next_b1;
      b2 <= next_b2;
      p0 <= next_p0;
      p1 <= next_p1;
      last_addr <= next_last_addr;
      len <= next_len;
    end
  end

  // Effective address and relative target
  logic use_y, use_idx, rmw;
  logic [7:0] idx, rel_off;
  logic [15:0] ea_base, ea_sum, pc_next, tgt_sum;

  always_comb begin
    use_y = (pre == PRE_Y) || (pre == PRE_IND_Y);
    idx = use_y ? idx_y : idx_x;
    use_idx = 1'b0;
    ea_base = 16'h0000;
    rel_off = 8'h00;
    case (mode)
      AM_DIR_SHORT, AM_BIT_DIR, AM_BIT_DIR_REL, AM_REL_IND: ea_base = {`CPUAMD_PAGE0, b1};
      AM_DIR_LONG: ea_base = {b1, b2};
      AM_IDX_NONE: use_idx = 1'b1;
      AM_IDX_SHORT: begin
        ea_base = {`CPUAMD_PAGE0, b1};
        use_idx = 1'b1;
      end
      AM_IDX_LONG: begin
        ea_base = {b1, b2};
        use_idx = 1'b1;
      end
      AM_IND_SHORT, AM_BIT_IND, AM_BIT_IND_REL: ea_base = {`CPUAMD_PAGE0, p0};
      AM_IND_LONG: ea_base = {p0, p1};
      AM_IND_IDX_SHORT: begin
        ea_base = {`CPUAMD_PAGE0, p0};
        use_idx = 1'b1;
      end
      AM_IND_IDX_LONG: begin
        ea_base = {p0, p1};
        use_idx = 1'b1;
      end
      default: ea_base = 16'h0000;
    endcase
    case (mode)
      AM_REL_DIR: rel_off = b1;
      AM_REL_IND: rel_off = p0;
      AM_BIT_DIR_REL, AM_BIT_IND_REL: rel_off = b2;
      default: rel_off = 8'h00;
    endcase
    rmw = is_rmw_row(opc);
    // Targets are taken from the byte after the instruction's last byte
    pc_next = 16'(last_addr + 16'h0001);
  end

  cpuamd_addr_add u_ea_add (
    .base(ea_base),
    .addend(use_idx ? idx : 8'h00),
    .sign_ext(1'b0),
    .sum(ea_sum)
  );

  cpuamd_addr_add u_tgt_add (
    .base(pc_next),
    .addend(rel_off),
    .sign_ext(1'b1),
    .sum(tgt_sum)
  );

  // Output group
  logic next_prog_ready, next_mem_rd_req, next_dec_valid, next_wait_req, next_halt_req;
  logic [15:0] next_mem_rd_addr;
  cpuamd_result_s next_dec;

  always_comb begin
    next_prog_ready = (next_state == S_OPC) || (next_state == S_OPR1) || (next_state == S_OPR2);
    // Request stands until the answer; a word pointer re-requests at once
    next_mem_rd_req = (next_state == S_PTR1) || (next_state == S_PTR2);
    next_mem_rd_addr = (next_state == S_PTR2) ? {`CPUAMD_PAGE0, 8'(next_b1 + 8'h01)}
                                              : {`CPUAMD_PAGE0, next_b1};
    next_dec_valid = (state == S_DONE);
    next_dec = dec;
    next_wait_req = 1'b0;
    next_halt_req = 1'b0;
    if (state == S_DONE) begin
      next_dec.mode = mode;
      next_dec.pre = pre;
      next_dec.use_y = use_y;
      next_dec.rmw = rmw;
      next_dec.length = len;
      next_dec.operand = (mode == AM_IMMEDIATE) ? b1 : rel_off;
      next_dec.ea = ea_sum;
      next_dec.pc_next = pc_next;
      next_dec.target = tgt_sum;
      next_wait_req = (pre == PRE_NONE) && (opc == `CPUAMD_OPC_WAIT);
      next_halt_req = (pre == PRE_NONE) && (opc == `CPUAMD_OPC_HALT);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_ready <= 1'b0;
      mem_rd_req <= 1'b0;
      mem_rd_addr <= 16'h0000;
      dec_valid <= 1'b0;
      dec <= '0;
      wait_req <= 1'b0;
      halt_req <= 1'b0;
    end else begin
      prog_ready <= next_prog_ready;
      mem_rd_req <= next_mem_rd_req;
      mem_rd_addr <= next_mem_rd_addr;
      dec_valid <= next_dec_valid;
      dec <= next_dec;
      wait_req <= next_wait_req;
      halt_req <= next_halt_req;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_opcode_take;
    state == S_OPC && take && !(pre == PRE_NONE && is_prebyte(prog.data));
  endsequence
  sequence s_short_ptr_answer;
    state == S_PTR1 && mem_rd_valid && ptr_reads(mode) == 2'h1;
  endsequence

  a_inherent_no_fetch: assert property (s_opcode_take ##0 mode_of(pre, prog.data) == AM_INHERENT
    |=> state == S_DONE ##1 dec_valid && dec.length == len_of_pre(dec.pre))
    else $error("inherent opcode fetched further bytes");
  a_imm_length: assert property (dec_valid && dec.mode == AM_IMMEDIATE
    |-> dec.length == 3'(len_of_pre(dec.pre) + `CPUAMD_ONE_BYTE))
    else $error("immediate length wrong");
  a_short_dir_page: assert property (dec_valid && dec.mode == AM_DIR_SHORT
    |-> dec.ea[15:8] == `CPUAMD_PAGE0)
    else $error("short direct left page zero");
  a_long_dir_len: assert property (dec_valid && dec.mode == AM_DIR_LONG
    |-> dec.length == 3'(len_of_pre(dec.pre) + 3'h2))
    else $error("long direct length wrong");
  a_idx_none_ea: assert property (dec_valid && dec.mode == AM_IDX_NONE
    |-> dec.ea == {`CPUAMD_PAGE0, (dec.use_y ? $past(idx_y) : $past(idx_x))})
    else $error("no-offset index address wrong");
  a_idx_short_range: assert property (dec_valid && dec.mode == AM_IDX_SHORT
    |-> dec.ea <= `CPUAMD_SHORT_IDX_MAX)
    else $error("short indexed address out of range");
  a_idx_long_len: assert property (dec_valid && dec.mode == AM_IDX_LONG
    |-> dec.length == 3'(len_of_pre(dec.pre) + 3'h2))
    else $error("long indexed length wrong");
  a_rmw_short_only: assert property (dec_valid && dec.rmw
    |-> !(dec.mode inside {AM_DIR_LONG, AM_IDX_LONG, AM_IND_LONG, AM_IND_IDX_LONG}))
    else $error("read-modify-write took a long form");
  a_rel_target: assert property (dec_valid && dec.mode == AM_REL_DIR
    |-> dec.target == 16'(dec.pc_next + {{8{dec.operand[7]}}, dec.operand}))
    else $error("relative target wrong");
  a_halt_pulse: assert property (halt_req || wait_req
    |-> dec_valid && dec.mode == AM_INHERENT ##1 !halt_req && !wait_req)
    else $error("low-power request not a single inherent pulse");
  a_short_ptr: assert property (s_short_ptr_answer |=> state == S_DONE && !mem_rd_req)
    else $error("short pointer read not single");
  a_prebyte_y: assert property (dec_valid && dec.pre inside {PRE_Y, PRE_IND_Y}
    |-> dec.use_y)
    else $error("second index prebyte ignored");
  a_mode_legal: assert property (dec_valid |-> dec.mode <= AM_BIT_IND_REL)
    else $error("mode code out of range");

  function automatic logic [2:0] len_of_pre(input cpuamd_pre_e p);
    len_of_pre = (p == PRE_NONE) ? `CPUAMD_LEN_OPC : 3'(`CPUAMD_LEN_OPC + `CPUAMD_LEN_PRE);
  endfunction
endmodule

//--- cpuamd_prog_mem.sv
// Program memory and page-zero pointer memory facing the decoder
`timescale 1ns/100ps
module cpuamd_prog_mem
  import cpuamd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [15:0] start_pc,
  input wire logic [2:0] n_bytes,
  input wire logic [1:0] rd_lat,
  output logic prog_valid,
  output cpuamd_prog_s prog,
  input wire logic prog_ready,
  input wire logic mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  output logic mem_rd_valid,
  output logic [7:0] mem_rd_data
);
  logic [7:0] code [256];
  logic [7:0] zp [256];
  logic [15:0] pc;
  logic [2:0] left;
  logic [1:0] wcnt;
  logic [7:0] cyc;

  // Idle bus shows a moving pattern so stale bytes are never mistaken for data
  assign prog_valid = (left != 3'h0);
  assign prog.addr = pc;
  assign prog.data = prog_valid ? code[pc[7:0]] : cyc;
  // Latency restarts per byte, so word pointers see the delay twice
  assign mem_rd_valid = mem_rd_req && (wcnt == rd_lat);
  assign mem_rd_data = mem_rd_valid ? zp[mem_rd_addr[7:0]] : ~cyc;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc <= 16'h0000;
      left <= 3'h0;
      wcnt <= 2'h0;
      cyc <= 8'h00;
    end else begin
      cyc <= cyc + 8'h01;
      if (load) begin
        pc <= start_pc;
        left <= n_bytes;
      end else if (prog_valid && prog_ready) begin
        pc <= pc + 16'h0001;
        left <= left - 3'h1;
      end
      if (mem_rd_valid || !mem_rd_req) begin
        wcnt <= 2'h0;
      end else begin
        wcnt <= wcnt + 2'h1;
      end
    end
  end
endmodule

//--- cpu_addressing_mode_decoder_test.sv
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
module cpu_addressing_mode_decoder_test import cpuamd_pkg::*;;
  logic core_clk, rst_n, load, prog_valid, prog_ready, mem_rd_req, mem_rd_valid;
  logic dec_valid, wait_req, halt_req, got_w, got_h;
  logic [15:0] start_pc, mem_rd_addr;
  logic [2:0] n_bytes;
  logic [1:0] rd_lat;
  logic [7:0] mem_rd_data, idx_x, idx_y;
  cpuamd_prog_s prog;
  cpuamd_result_s dec;
  int error_cnt = 0;
  int checks = 0;

  cpuamd_decoder i_cpuamd_decoder (
    .core_clk(core_clk), .rst_n(rst_n), .prog_valid(prog_valid), .prog(prog),
    .prog_ready(prog_ready), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data), .idx_x(idx_x),
    .idx_y(idx_y), .dec_valid(dec_valid), .dec(dec), .wait_req(wait_req),
    .halt_req(halt_req)
  );

  cpuamd_prog_mem i_cpuamd_prog_mem (
    .core_clk(core_clk), .rst_n(rst_n), .load(load), .start_pc(start_pc),
    .n_bytes(n_bytes), .rd_lat(rd_lat), .prog_valid(prog_valid), .prog(prog),
    .prog_ready(prog_ready), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Streams up to four bytes and waits for the finished decode
  task automatic run(input logic [15:0] pc, input logic [2:0] n, input logic [31:0] b,
                     input logic [1:0] lat);
    int k;
    for (k = 0; k < 4; k++) begin
      i_cpuamd_prog_mem.code[8'(pc + 16'(k))] = b[31 - 8 * k -: 8];
    end
    start_pc = pc;
    n_bytes = n;
    rd_lat = lat;
    load = 1'b1;
    @(posedge core_clk);
    #1 load = 1'b0;
    for (k = 0; k < 60 && dec_valid !== 1'b1; k++) begin
      @(posedge core_clk);
      #1;
    end
    chk({15'h0, dec_valid}, 16'h0001);
    got_w = wait_req;
    got_h = halt_req;
  endtask

  task automatic expect_dec(input cpuamd_mode_e m, input logic [2:0] len,
                            input logic [15:0] pcn);
    chk(16'(dec.mode), 16'(m));
    chk(16'(dec.length), 16'(len));
    chk(dec.pc_next, pcn);
  endtask

  task automatic t_inherent();
    run(16'h0100, 3'h1, 32'h9d000000, 2'h0);
    expect_dec(AM_INHERENT, 3'h1, 16'h0101);
    chk({14'h0, got_w, got_h}, 16'h0000);
    run(16'h0110, 3'h1, 32'h8f000000, 2'h0);
    chk({14'h0, got_w, got_h}, 16'h0002);
    run(16'h0120, 3'h1, 32'h8e000000, 2'h0);
    chk({14'h0, got_w, got_h}, 16'h0001);
  endtask

  task automatic t_direct();
    run(16'h0200, 3'h2, 32'hb7100000, 2'h0);
    expect_dec(AM_DIR_SHORT, 3'h2, 16'h0202);
    chk(dec.ea, 16'h0010);
    chk({15'h0, dec.rmw}, 16'h0000);
    run(16'h0210, 3'h3, 32'hc7123400, 2'h0);
    expect_dec(AM_DIR_LONG, 3'h3, 16'h0213);
    chk(dec.ea, 16'h1234);
    run(16'h0220, 3'h2, 32'ha6550000, 2'h0);
    expect_dec(AM_IMMEDIATE, 3'h2, 16'h0222);
    chk({8'h0, dec.operand}, 16'h0055);
  endtask

  task automatic t_indexed();
    idx_x = 8'hff;
    idx_y = 8'h20;
    run(16'h0300, 3'h1, 32'hf7000000, 2'h0);
    expect_dec(AM_IDX_NONE, 3'h1, 16'h0301);
    chk(dec.ea, 16'h00ff);
    run(16'h0310, 3'h2, 32'he7ff0000, 2'h0);
    expect_dec(AM_IDX_SHORT, 3'h2, 16'h0312);
    chk(dec.ea, 16'h01fe);
    run(16'h0320, 3'h3, 32'hd7123400, 2'h0);
    expect_dec(AM_IDX_LONG, 3'h3, 16'h0323);
    chk(dec.ea, 16'h1333);
    run(16'h0330, 3'h3, 32'h90e71000, 2'h0);
    expect_dec(AM_IDX_SHORT, 3'h3, 16'h0333);
    chk({13'h0, dec.pre, dec.use_y}, 16'h0003);
    chk(dec.ea, 16'h0030);
    run(16'h0340, 3'h2, 32'h90f70000, 2'h0);
    expect_dec(AM_IDX_NONE, 3'h2, 16'h0342);
    chk(dec.ea, 16'h0020);
  endtask

  task automatic t_indirect();
    i_cpuamd_prog_mem.zp[8'h10] = 8'h44;
    i_cpuamd_prog_mem.zp[8'h30] = 8'h12;
    i_cpuamd_prog_mem.zp[8'h31] = 8'h34;
    i_cpuamd_prog_mem.zp[8'h20] = 8'hf0;
    run(16'h0400, 3'h3, 32'h92b71000, 2'h0);
    expect_dec(AM_IND_SHORT, 3'h3, 16'h0403);
    chk(dec.ea, 16'h0044);
    run(16'h0410, 3'h3, 32'h92c73000, 2'h2);
    expect_dec(AM_IND_LONG, 3'h3, 16'h0413);
    chk(dec.ea, 16'h1234);
    run(16'h0420, 3'h3, 32'h91e72000, 2'h1);
    expect_dec(AM_IND_IDX_SHORT, 3'h3, 16'h0423);
    chk({13'h0, dec.pre, dec.use_y}, 16'h0007);
    chk(dec.ea, 16'h0110);
    run(16'h0430, 3'h3, 32'h92d73000, 2'h0);
    expect_dec(AM_IND_IDX_LONG, 3'h3, 16'h0433);
    chk(dec.ea, 16'h1333);
    run(16'h0440, 3'h3, 32'h92221000, 2'h0);
    expect_dec(AM_REL_IND, 3'h3, 16'h0443);
    chk(dec.target, 16'h0487);
    run(16'h0450, 3'h3, 32'h92151000, 2'h0);
    expect_dec(AM_BIT_IND, 3'h3, 16'h0453);
    chk(dec.ea, 16'h0044);
    chk({15'h0, dec.rmw}, 16'h0001);
  endtask

  task automatic t_relative();
    run(16'h0500, 3'h2, 32'h20fe0000, 2'h0);
    expect_dec(AM_REL_DIR, 3'h2, 16'h0502);
    chk(dec.target, 16'h0500);
    run(16'h0510, 3'h2, 32'h207f0000, 2'h0);
    chk(dec.target, 16'h0591);
    run(16'h0520, 3'h2, 32'h20800000, 2'h0);
    chk(dec.target, 16'h04a2);
  endtask

  task automatic t_rmw_bit();
    i_cpuamd_prog_mem.zp[8'h40] = 8'h25;
    run(16'h0600, 3'h2, 32'h3c100000, 2'h0);
    expect_dec(AM_DIR_SHORT, 3'h2, 16'h0602);
    chk({15'h0, dec.rmw}, 16'h0001);
    run(16'h0620, 3'h2, 32'h10200000, 2'h0);
    expect_dec(AM_BIT_DIR, 3'h2, 16'h0622);
    chk({15'h0, dec.rmw}, 16'h0001);
    run(16'h0630, 3'h3, 32'h00200500, 2'h0);
    expect_dec(AM_BIT_DIR_REL, 3'h3, 16'h0633);
    chk(dec.target, 16'h0638);
    run(16'h0640, 3'h4, 32'h920040fe, 2'h1);
    expect_dec(AM_BIT_IND_REL, 3'h4, 16'h0644);
    chk(dec.ea, 16'h0025);
    chk(dec.target, 16'h0642);
    run(16'h0650, 3'h2, 32'h6c050000, 2'h0);
    expect_dec(AM_IDX_SHORT, 3'h2, 16'h0652);
    chk({15'h0, dec.rmw}, 16'h0001);
    chk(dec.ea, 16'h0104);
    run(16'h0660, 3'h1, 32'h7c000000, 2'h0);
    expect_dec(AM_IDX_NONE, 3'h1, 16'h0661);
    chk({15'h0, dec.rmw}, 16'h0001);
    // A prebyte ahead of the wait opcode makes it a different instruction
    run(16'h0670, 3'h2, 32'h908f0000, 2'h0);
    expect_dec(AM_INHERENT, 3'h2, 16'h0672);
    chk({14'h0, got_w, got_h}, 16'h0000);
  endtask

  initial begin
    #(4 * 5000);
    error_cnt++;
    $display("FAIL t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    load = 1'b0;
    start_pc = 16'h0000;
    n_bytes = 3'h0;
    rd_lat = 2'h0;
    idx_x = 8'h00;
    idx_y = 8'h00;
    got_w = 1'b0;
    got_h = 1'b0;
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    t_inherent();
    t_direct();
    t_indexed();
    t_indirect();
    t_relative();
    t_rmw_bit();
    print_verdict();
  end
endmodule
